/* File: inc/refctl_cfg.svh */
// Register map, field positions, codes and timing figures of the reference control block
`ifndef REFCTL_CFG_SVH
`define REFCTL_CFG_SVH

`define REFCTL_ADDR_W 4
`define REFCTL_DATA_W 8
`define REFCTL_ADDR_CTRL 4'h0

`define REFCTL_CTRL_RESET 8'h00
`define REFCTL_WRITE_MASK 8'hBF
`define REFCTL_ZERO_BYTE 8'h00

`define REFCTL_BIT_REF_EN 7
`define REFCTL_BIT_READY 6
`define REFCTL_BIT_TS_EN 5
`define REFCTL_BIT_TS_RNG 4
`define REFCTL_CMP_HI 3
`define REFCTL_CMP_LO 2
`define REFCTL_ADC_HI 1
`define REFCTL_ADC_LO 0

`define REFCTL_GAIN_OFF 2'h0
`define REFCTL_GAIN_X1 2'h1
`define REFCTL_GAIN_X2 2'h2
`define REFCTL_GAIN_X4 2'h3

`define REFCTL_CLK_PERIOD_NS 25
`define REFCTL_SETTLE_NS 25000

`endif

/* File: inc/refctl_pkg.sv */
// Types shared by the reference control block
package refctl_pkg;
   typedef logic [7:0] ctrl_t;
   typedef logic [1:0] buf_gain_t;
   typedef enum logic [1:0] {ST_OFF, ST_SETTLING, ST_READY} settle_e;
endpackage

/* File: logic/ref_settle_timer.sv */
// Settling timer: counts a fixed number of cycles after each restart
`timescale 1ns/100ps
module ref_settle_timer #(
   parameter int CYCLES = 1000
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Control
   input wire logic run,
   input wire logic restart,
   // Status
   output logic done
);
   localparam int CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] RELOAD = CNT_W'(CYCLES - 1);
   localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic done_reg;
   logic done_next;
   wire logic cnt_zero = (cnt_reg == '0);

   assign cnt_next = (!run || restart) ? RELOAD : (cnt_zero ? cnt_reg : cnt_reg - ONE);
   assign done_next = run && !restart && cnt_zero;
   assign done = done_reg;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_reg <= '0;
         done_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         done_reg <= done_next;
      end
   end
endmodule

/* File: logic/reference_control_register.sv */
// Control and status register of the fixed reference and temperature sensor
//
// How it works
// - Temperature sensor runs while control bit 5 is one, off while zero.
// - Bit 4 one picks high sensor range (four drops), zero low range (two).
// - Comparator gain field bits 3-2: 01 unity, 10 double, 11 quadruple.
// - Comparator gain field 00 switches the comparator reference buffer off.
// - Reference enable bit turns the fixed reference on, clearing it turns it off.
// - Ready flag rises only after reference and buffers have settled following enable.
// - Converter gain field bits 1-0 decodes off, unity, double, quadruple likewise.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "refctl_cfg.svh"
module reference_control_register #(
   parameter int ADDR_W = `REFCTL_ADDR_W,
   parameter int SETTLE_NS = `REFCTL_SETTLE_NS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [`REFCTL_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`REFCTL_DATA_W-1:0] reg_rdata,
   // Analog status pin
   input wire logic ref_stable_pin,
   // Reference and sensor controls
   output logic ref_enable,
   output logic ref_ready_flag,
   output logic temp_sense_enable,
   output logic temp_range_select,
   // Comparator path buffer
   output logic comparator_buffer_on,
   output logic comparator_gain_x1,
   output logic comparator_gain_x2,
   output logic comparator_gain_x4,
   // Converter path buffer
   output logic converter_buffer_on,
   output logic converter_gain_x1,
   output logic converter_gain_x2,
   output logic converter_gain_x4
);
   localparam int SETTLE_CYCLES = (SETTLE_NS + `REFCTL_CLK_PERIOD_NS - 1) / `REFCTL_CLK_PERIOD_NS;
   localparam int NBUF = 2;

   refctl_pkg::ctrl_t ctrl_reg;
   refctl_pkg::ctrl_t ctrl_next;
   refctl_pkg::settle_e state_reg;
   refctl_pkg::settle_e state_next;
   logic [`REFCTL_DATA_W-1:0] rdata_reg;
   logic [`REFCTL_DATA_W-1:0] rdata_next;
   logic ref_en_reg;
   logic ready_reg;
   logic ts_en_reg;
   logic ts_rng_reg;
   logic [NBUF-1:0] buf_on_reg;
   logic [NBUF-1:0] gain_x1_reg;
   logic [NBUF-1:0] gain_x2_reg;
   logic [NBUF-1:0] gain_x4_reg;
   logic stable_s1_reg;
   logic stable_s2_reg;
   logic stable_s3_reg;
   logic stable_reg;
   logic stable_next;
   logic timer_done;
   refctl_pkg::buf_gain_t gain_field [NBUF];

   // Bus decode
   wire logic ctrl_hit = (reg_addr == ADDR_W'(`REFCTL_ADDR_CTRL));
   wire logic ctrl_write = reg_wr && ctrl_hit;
   wire logic ctrl_read = reg_rd && ctrl_hit;

   assign ctrl_next = ctrl_write ? (reg_wdata & `REFCTL_WRITE_MASK) : ctrl_reg;

   wire logic ref_en_next = ctrl_next[`REFCTL_BIT_REF_EN];
   wire logic gains_change = ctrl_write &&
      (ctrl_next[`REFCTL_CMP_HI:`REFCTL_ADC_LO] != ctrl_reg[`REFCTL_CMP_HI:`REFCTL_ADC_LO]);
   wire logic settle_restart = (ref_en_next && !ctrl_reg[`REFCTL_BIT_REF_EN]) || gains_change;

   // Read data with live ready flag
   wire refctl_pkg::ctrl_t ctrl_view = {ctrl_reg[`REFCTL_BIT_REF_EN], ready_reg,
      ctrl_reg[`REFCTL_BIT_TS_EN:`REFCTL_ADC_LO]};
   assign rdata_next = ctrl_read ? ctrl_view : `REFCTL_ZERO_BYTE;

   // Pin filter: change taken when second and third stages agree
   assign stable_next = (stable_s2_reg == stable_s3_reg) ? stable_s3_reg : stable_reg;

   assign gain_field[0] = ctrl_next[`REFCTL_CMP_HI:`REFCTL_CMP_LO];
   assign gain_field[1] = ctrl_next[`REFCTL_ADC_HI:`REFCTL_ADC_LO];

   ref_settle_timer #(
      .CYCLES(SETTLE_CYCLES)
   ) settle_timer (
      .clk(clk),
      .reset_n(reset_n),
      .run(ref_en_next),
      .restart(settle_restart),
      .done(timer_done)
   );

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         refctl_pkg::ST_OFF:
         begin
            if (ref_en_next)
               state_next = refctl_pkg::ST_SETTLING;
         end
         refctl_pkg::ST_SETTLING:
         begin
            if (!ref_en_next)
               state_next = refctl_pkg::ST_OFF;
            else if (timer_done && stable_reg && !settle_restart)
               state_next = refctl_pkg::ST_READY;
         end
         refctl_pkg::ST_READY:
         begin
            if (!ref_en_next)
               state_next = refctl_pkg::ST_OFF;
            else if (settle_restart || !stable_reg)
               state_next = refctl_pkg::ST_SETTLING;
         end
         default:
         begin
            state_next = refctl_pkg::ST_OFF;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_reg <= `REFCTL_CTRL_RESET;
         rdata_reg <= `REFCTL_ZERO_BYTE;
         state_reg <= refctl_pkg::ST_OFF;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         rdata_reg <= rdata_next;
         state_reg <= state_next;
      end
   end

   // Synchroniser for the analog stable level
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stable_s1_reg <= 1'b0;
         stable_s2_reg <= 1'b0;
         stable_s3_reg <= 1'b0;
         stable_reg <= 1'b0;
      end
      else
      begin
         stable_s1_reg <= ref_stable_pin;
         stable_s2_reg <= stable_s1_reg;
         stable_s3_reg <= stable_s2_reg;
         stable_reg <= stable_next;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ref_en_reg <= 1'b0;
         ready_reg <= 1'b0;
         ts_en_reg <= 1'b0;
         ts_rng_reg <= 1'b0;
      end
      else
      begin
         ref_en_reg <= ref_en_next;
         ready_reg <= (state_next == refctl_pkg::ST_READY);
         ts_en_reg <= ctrl_next[`REFCTL_BIT_TS_EN];
         ts_rng_reg <= ctrl_next[`REFCTL_BIT_TS_RNG];
      end
   end

   genvar b;
   generate
      for (b = 0; b < NBUF; b++)
      begin : g_buf
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               buf_on_reg[b] <= 1'b0;
               gain_x1_reg[b] <= 1'b0;
               gain_x2_reg[b] <= 1'b0;
               gain_x4_reg[b] <= 1'b0;
            end
            else
            begin
               buf_on_reg[b] <= (gain_field[b] != `REFCTL_GAIN_OFF);
               gain_x1_reg[b] <= (gain_field[b] == `REFCTL_GAIN_X1);
               gain_x2_reg[b] <= (gain_field[b] == `REFCTL_GAIN_X2);
               gain_x4_reg[b] <= (gain_field[b] == `REFCTL_GAIN_X4);
            end
         end
      end
   endgenerate

   // Outputs
   assign reg_rdata = rdata_reg;
   assign ref_enable = ref_en_reg;
   assign ref_ready_flag = ready_reg;
   assign temp_sense_enable = ts_en_reg;
   assign temp_range_select = ts_rng_reg;
   assign comparator_buffer_on = buf_on_reg[0];
   assign comparator_gain_x1 = gain_x1_reg[0];
   assign comparator_gain_x2 = gain_x2_reg[0];
   assign comparator_gain_x4 = gain_x4_reg[0];
   assign converter_buffer_on = buf_on_reg[1];
   assign converter_gain_x1 = gain_x1_reg[1];
   assign converter_gain_x2 = gain_x2_reg[1];
   assign converter_gain_x4 = gain_x4_reg[1];

   // Checks
   default clocking chk_cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // Cycles since the reference was last enabled or its gains changed
   logic [15:0] en_age_reg;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         en_age_reg <= 16'h0000;
      else if (!ref_en_next || settle_restart)
         en_age_reg <= 16'h0000;
      else if (en_age_reg != 16'hFFFF)
         en_age_reg <= en_age_reg + 16'h0001;
   end

   sequence seq_disable_write;
      reg_wr && ctrl_hit && !reg_wdata[`REFCTL_BIT_REF_EN];
   endsequence

   sequence seq_ref_down;
      !ref_enable && !ref_ready_flag ##1 !ref_ready_flag;
   endsequence

   AST_TEMP_ENABLE: assert property ((reg_wr && ctrl_hit) |=>
      temp_sense_enable == $past(reg_wdata[`REFCTL_BIT_TS_EN]))
      else $error("sensor enable does not follow written bit");

   AST_TEMP_RANGE: assert property ((reg_wr && ctrl_hit) |=>
      temp_range_select == $past(reg_wdata[`REFCTL_BIT_TS_RNG]))
      else $error("sensor range does not follow written bit");

   AST_CMP_GAIN_X2: assert property ((reg_wr && ctrl_hit &&
      reg_wdata[`REFCTL_CMP_HI:`REFCTL_CMP_LO] == `REFCTL_GAIN_X2)
      |=> comparator_gain_x2 && comparator_buffer_on && !comparator_gain_x1 && !comparator_gain_x4)
      else $error("comparator gain code 10 not decoded as double");

   AST_CMP_OFF: assert property ((reg_wr && ctrl_hit &&
      reg_wdata[`REFCTL_CMP_HI:`REFCTL_CMP_LO] == `REFCTL_GAIN_OFF)
      |=> !comparator_buffer_on && !(comparator_gain_x1 || comparator_gain_x2 || comparator_gain_x4))
      else $error("comparator buffer not off at code 00");

   AST_REF_OFF: assert property (seq_disable_write |=> seq_ref_down)
      else $error("reference not disabled by cleared enable bit");

   AST_READY_SETTLED: assert property ($rose(ref_ready_flag) |->
      ref_enable && en_age_reg >= 16'(SETTLE_CYCLES))
      else $error("ready flag set before settling time");

   AST_ADC_GAIN_X4: assert property ((reg_wr && ctrl_hit &&
      reg_wdata[`REFCTL_ADC_HI:`REFCTL_ADC_LO] == `REFCTL_GAIN_X4)
      |=> converter_gain_x4 && converter_buffer_on && !converter_gain_x1 && !converter_gain_x2)
      else $error("converter gain code 11 not decoded as quadruple");

   AST_READY_NOT_WRITABLE: assert property ((reg_wr && ctrl_hit &&
      reg_wdata[`REFCTL_BIT_READY] && !reg_wdata[`REFCTL_BIT_REF_EN]) ##1 reg_rd
      |=> !reg_rdata[`REFCTL_BIT_READY])
      else $error("ready flag took a software write");
endmodule

/* File: tb/reference_control_register_tb_top.sv */
// Self-checking testbench of the reference control register
`timescale 1ns/100ps
`include "refctl_cfg.svh"
module reference_control_register_tb_top;
   localparam int SETTLE_NS = 250;
   localparam int WAIT_LIM = 60;
   logic clk;
   logic reset_n;
   logic [`REFCTL_ADDR_W-1:0] reg_addr;
   logic [`REFCTL_DATA_W-1:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [`REFCTL_DATA_W-1:0] reg_rdata;
   logic ref_stable_pin;
   logic ref_enable, ref_ready_flag, temp_sense_enable, temp_range_select;
   logic comparator_buffer_on, comparator_gain_x1, comparator_gain_x2, comparator_gain_x4;
   logic converter_buffer_on, converter_gain_x1, converter_gain_x2, converter_gain_x4;
   int num_errors;
   int cmp_count;
   refctl_pkg::ctrl_t rd_val;
   refctl_pkg::ctrl_t wdat;

   reference_control_register #(.ADDR_W(`REFCTL_ADDR_W), .SETTLE_NS(SETTLE_NS)) DUT (
      .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_stable_pin(ref_stable_pin),
      .ref_enable(ref_enable), .ref_ready_flag(ref_ready_flag),
      .temp_sense_enable(temp_sense_enable), .temp_range_select(temp_range_select),
      .comparator_buffer_on(comparator_buffer_on), .comparator_gain_x1(comparator_gain_x1),
      .comparator_gain_x2(comparator_gain_x2), .comparator_gain_x4(comparator_gain_x4),
      .converter_buffer_on(converter_buffer_on), .converter_gain_x1(converter_gain_x1),
      .converter_gain_x2(converter_gain_x2), .converter_gain_x4(converter_gain_x4));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic check(input refctl_pkg::ctrl_t seen, input refctl_pkg::ctrl_t exp);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      if (num_errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // One write cycle, outputs sampled once the write has landed
   task automatic reg_write(input logic [`REFCTL_ADDR_W-1:0] a, input refctl_pkg::ctrl_t d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   // One read cycle, data taken in the following cycle
   task automatic reg_read(input logic [`REFCTL_ADDR_W-1:0] a, output refctl_pkg::ctrl_t d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic wait_ready;
      int n;
      n = 0;
      while (ref_ready_flag !== 1'b1 && n < WAIT_LIM)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (ref_ready_flag !== 1'b1)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: ready flag never set", $time);
         wrap_up();
      end
   endtask

   function automatic logic [3:0] dec(input logic [1:0] c);
      dec = {c != `REFCTL_GAIN_OFF, c == `REFCTL_GAIN_X1, c == `REFCTL_GAIN_X2, c == `REFCTL_GAIN_X4};
   endfunction

   function automatic refctl_pkg::ctrl_t outs();
      outs = {ref_enable, ref_ready_flag, temp_sense_enable, temp_range_select,
              comparator_buffer_on, converter_buffer_on, 2'h0};
   endfunction

   initial
   begin
      num_errors = 0;
      cmp_count = 0;
      reset_n = 1'b0;
      reg_addr = '0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      ref_stable_pin = 1'b0;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      #1;
      check(outs(), 8'h00);
      reg_read(`REFCTL_ADDR_CTRL, rd_val);
      check(rd_val, `REFCTL_CTRL_RESET);
      // Sweep sensor bits and both gain fields, ready bit written high
      for (int i = 0; i < 16; i++)
      begin
         wdat = {2'h1, i[0], ~i[3], i[3:0]};
         reg_write(`REFCTL_ADDR_CTRL, wdat);
         check({4'h0, temp_sense_enable, temp_range_select, 2'h0}, {4'h0, wdat[5], wdat[4], 2'h0});
         check({comparator_buffer_on, comparator_gain_x1, comparator_gain_x2, comparator_gain_x4,
                converter_buffer_on, converter_gain_x1, converter_gain_x2, converter_gain_x4},
               {dec(wdat[3:2]), dec(wdat[1:0])});
         check({6'h0, ref_enable, ref_ready_flag}, 8'h00);
         reg_read(`REFCTL_ADDR_CTRL, rd_val);
         check(rd_val, wdat & `REFCTL_WRITE_MASK);
      end
      @(posedge clk);
      #1;
      check(reg_rdata, `REFCTL_ZERO_BYTE);
      // Back-to-back write and read, ready bit written high
      wdat = 8'h55;
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= `REFCTL_ADDR_CTRL;
      reg_wdata <= wdat;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, wdat & `REFCTL_WRITE_MASK);
      // Unmapped address leaves the register alone and reads zero
      reg_write(4'h5, 8'hFF);
      reg_read(`REFCTL_ADDR_CTRL, rd_val);
      check(rd_val, wdat & `REFCTL_WRITE_MASK);
      reg_read(4'h5, rd_val);
      check(rd_val, `REFCTL_ZERO_BYTE);
      // Enable with reference not yet stable: no ready flag
      reg_write(`REFCTL_ADDR_CTRL, 8'h80);
      check({7'h0, ref_enable}, 8'h01);
      repeat (WAIT_LIM) @(posedge clk);
      #1;
      check({7'h0, ref_ready_flag}, 8'h00);
      @(posedge clk);
      ref_stable_pin <= 1'b1;
      wait_ready();
      reg_write(`REFCTL_ADDR_CTRL, 8'h00);
      @(posedge clk);
      #1;
      check({6'h0, ref_enable, ref_ready_flag}, 8'h00);
      // Fresh enable: flag stays low during the settling count
      reg_write(`REFCTL_ADDR_CTRL, 8'h85);
      repeat (5) @(posedge clk);
      #1;
      check({7'h0, ref_ready_flag}, 8'h00);
      wait_ready();
      reg_read(`REFCTL_ADDR_CTRL, rd_val);
      check(rd_val, 8'hC5);
      // Gain change restarts settling
      reg_write(`REFCTL_ADDR_CTRL, 8'h8A);
      @(posedge clk);
      #1;
      check({7'h0, ref_ready_flag}, 8'h00);
      wait_ready();
      // Loss of the stable indication drops the flag
      @(posedge clk);
      ref_stable_pin <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      check({7'h0, ref_ready_flag}, 8'h00);
      // Reset in mid-run clears everything
      reg_write(`REFCTL_ADDR_CTRL, 8'hBF);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check(outs(), 8'h00);
      @(posedge clk);
      reset_n <= 1'b1;
      reg_read(`REFCTL_ADDR_CTRL, rd_val);
      check(rd_val, `REFCTL_CTRL_RESET);
      wrap_up();
   end
endmodule
